// >>> design/adcsc_pkg.sv
package adcsc_pkg;
   // control word layout, as written by the host
   localparam int CTRL_W = 14;
   localparam int CTRL_PM_HI = 9;
   localparam int CTRL_PM_LO = 8;
   localparam int CTRL_RS_HI = 7;
   localparam int CTRL_RS_LO = 6;
   localparam int CTRL_MODE = 5;
   localparam int CTRL_CONV = 4;
   localparam int CTRL_KIND = 3;
   localparam int CTRL_CS_HI = 2;
   localparam int CTRL_CS_LO = 1;
   localparam int CTRL_START = 0;

   // status word layout
   localparam int STAT_W = 16;
   localparam int STAT_BUSY = 14;
   localparam int STAT_PM_HI = 9;
   localparam int STAT_PM_LO = 8;
   localparam int STAT_ONE_HI = 7;
   localparam int STAT_ONE_LO = 6;
   localparam int STAT_MODE = 5;
   localparam int STAT_KIND = 3;
   localparam int STAT_CS_HI = 2;
   localparam int STAT_CS_LO = 1;
   localparam int STAT_CAL = 0;
   localparam logic [15:0] STAT_RESET = 16'h0000;

   // read-select codes
   localparam logic [1:0] RSEL_RESULT = 2'h0;
   localparam logic [1:0] RSEL_SPARE = 2'h1;
   localparam logic [1:0] RSEL_CAL = 2'h2;
   localparam logic [1:0] RSEL_STATUS = 2'h3;

   // calibration selection codes
   localparam logic [1:0] CSEL_ALL = 2'h0;
   localparam logic [1:0] CSEL_GAIN_OFS = 2'h1;
   localparam logic [1:0] CSEL_OFS = 2'h2;
   localparam logic [1:0] CSEL_GAIN = 2'h3;

   // calibration register file
   localparam int CAL_W = 14;
   localparam int CAL_N = 10;
   localparam int CAL_IDX_W = 4;
   localparam logic [3:0] CAL_IDX_GAIN = 4'h0;
   localparam logic [3:0] CAL_IDX_OFS = 4'h1;
   localparam logic [3:0] CAL_IDX_DAC0 = 4'h2;
   localparam logic [3:0] CAL_IDX_LAST = 4'h9;
   localparam logic [13:0] CAL_OFS_RESET = 14'h2000;
   localparam logic [13:0] CAL_OTHER_RESET = 14'h0000;
   localparam logic [1:0] CAL_PAD = 2'h0;
endpackage : adcsc_pkg

// >>> design/adcsc_cal_ptr.sv
`timescale 1ns/1ps
// walks the selected calibration set; restart wins over advance
module adcsc_cal_ptr
   import adcsc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic restart,
   input wire logic advance,
   input wire logic [1:0] sel,
   output logic [CAL_IDX_W-1:0] ptr
);
   logic [CAL_IDX_W-1:0] ptr_q;
   logic [CAL_IDX_W-1:0] ptr_d;
   logic [CAL_IDX_W-1:0] first;
   logic [CAL_IDX_W-1:0] last;

   // first and last entry of each set; dac entries follow gain and offset
   always_comb begin
      first = (sel == CSEL_OFS) ? CAL_IDX_OFS : CAL_IDX_GAIN;
      unique case (sel)
         CSEL_ALL: last = CAL_IDX_LAST;
         CSEL_GAIN_OFS: last = CAL_IDX_OFS;
         CSEL_OFS: last = CAL_IDX_OFS;
         CSEL_GAIN: last = CAL_IDX_GAIN;
      endcase
   end

   // next pointer value
   always_comb begin
      ptr_d = ptr_q;
      if (restart) begin
         ptr_d = first;
      end else if (advance) begin
         if (ptr_q == last) begin
            ptr_d = first;
         end else begin
            ptr_d = ptr_q + 4'h1;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ptr_q <= CAL_IDX_GAIN;
      end else begin
         ptr_q <= ptr_d;
      end
   end

   assign ptr = ptr_q;
endmodule : adcsc_cal_ptr

// >>> design/adcsc_cal_regs.sv
`timescale 1ns/1ps
// ten calibration words: one write port, two read ports
module adcsc_cal_regs
   import adcsc_pkg::*;
#(
   parameter int N = CAL_N,
   parameter int W = CAL_W
)(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [CAL_IDX_W-1:0] wr_idx,
   input wire logic [W-1:0] wr_data,
   input wire logic [CAL_IDX_W-1:0] rd_idx_a,
   output logic [W-1:0] rd_data_a,
   input wire logic [CAL_IDX_W-1:0] rd_idx_b,
   output logic [W-1:0] rd_data_b
);
   logic [W-1:0] mem_q [N];
   logic [W-1:0] mem_d [N];

   // one entry per word; an out-of-range index writes nothing
   for (genvar i = 0; i < N; i++) begin : g_word
      always_comb begin
         mem_d[i] = mem_q[i];
         if (wr_en && (wr_idx == CAL_IDX_W'(i))) begin
            mem_d[i] = wr_data;
         end
      end
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            mem_q[i] <= (i == int'(CAL_IDX_OFS)) ? CAL_OFS_RESET : CAL_OTHER_RESET;
         end else begin
            mem_q[i] <= mem_d[i];
         end
      end
   end

   // reads past the last word return zero
   assign rd_data_a = (int'(rd_idx_a) < N) ? mem_q[rd_idx_a] : '0;
   assign rd_data_b = (int'(rd_idx_b) < N) ? mem_q[rd_idx_b] : '0;
endmodule : adcsc_cal_regs

// >>> design/adcsc_regs.sv
`timescale 1ns/1ps
// How it works
// - status word is sixteen bits, read only; writes never change it
// - the status copy is all zero after power-up, until the first status read
// - status bit 15 and bits 13 to 10 always read zero
// - status bit 14 is one during a conversion or a calibration
// - status bits 9 and 8 mirror the power-management control bits
// - status bits 7 and 6 read one on every status read
// - bit 5 shows interface mode, cleared after every read without a control write in that cycle; bit 4 don't care
// - status bit 3 is zero for self, one for system calibration
// - status bit 0 is one while a calibration runs
// - status bits 2 and 1 show the calibration selection code
// - ten readable and writable calibration registers: eight dac, offset, gain
// - calibration runs update the calibration registers without host writes
// - selection 00 all ten, 01 gain and offset, 10 offset, 11 gain
// - pointer restarts on a control write and after the last access of a set
// - pointer restarts at gain, or at offset for offset-only selection
// - pointer steps by one after each access when the set has several
// - host may stop early; the next control write restarts the pointer
// - calibration reads return the two top bits as zero
// - control bits 7 and 6 choose which register a read returns
// - with the start bit clear the selection bits address calibration words
// - calibration words are fourteen data bits under two zero bits
module adcsc_regs
   import adcsc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   // control register write, one word per pulse
   input wire logic ctrl_wr_valid,
   input wire logic [CTRL_W-1:0] ctrl_wr_data,
   // calibration word write, one word per pulse
   input wire logic cal_wr_valid,
   input wire logic [CAL_W-1:0] cal_wr_data,
   // read cycle request and its answer
   input wire logic rd_req,
   output logic rd_valid,
   output logic [STAT_W-1:0] rd_data,
   // conversion engine side
   input wire logic [CAL_W-1:0] conv_result,
   input wire logic conv_busy,
   input wire logic cal_busy,
   input wire logic cal_upd_valid,
   input wire logic [CAL_IDX_W-1:0] cal_upd_index,
   input wire logic [CAL_W-1:0] cal_upd_data,
   input wire logic [CAL_IDX_W-1:0] coef_index,
   output logic [CAL_W-1:0] coef_data,
   // decoded control state
   output logic [1:0] power_mgmt,
   output logic interface_mode1,
   output logic calibration_kind,
   output logic [1:0] cal_select,
   output logic conversion_trigger,
   output logic calibration_start_flag,
   output logic conv_start_pulse,
   output logic cal_start_pulse,
   output logic [CAL_IDX_W-1:0] cal_pointer,
   output logic [STAT_W-1:0] status_word
);
   // control register state
   logic [1:0] pm_q, pm_d;
   logic [1:0] rsel_q, rsel_d;
   logic mode_q, mode_d;
   logic conv_q, conv_d;
   logic kind_q, kind_d;
   logic [1:0] csel_q, csel_d;
   logic start_q, start_d;
   logic conv_pls_q, conv_pls_d;
   logic cal_pls_q, cal_pls_d;
   logic conv_busy_q, conv_busy_d;
   logic cal_busy_q, cal_busy_d;

   // read answer state
   logic rd_valid_q, rd_valid_d;
   logic [STAT_W-1:0] rd_data_q, rd_data_d;
   logic [STAT_W-1:0] stat_q, stat_d;

   // glue
   logic [STAT_W-1:0] status_now;
   logic cal_rd;
   logic cal_adv;
   logic [CAL_IDX_W-1:0] ptr;
   logic [1:0] ptr_sel;
   logic [CAL_W-1:0] ptr_word;
   logic rf_wr;
   logic [CAL_IDX_W-1:0] rf_idx;
   logic [CAL_W-1:0] rf_data;
   logic conv_done;
   logic cal_done;

   // previous busy levels; the engine is on this clock, so no synchroniser
   always_comb begin
      conv_busy_d = conv_busy;
      cal_busy_d = cal_busy;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         conv_busy_q <= 1'b0;
         cal_busy_q <= 1'b0;
      end else begin
         conv_busy_q <= conv_busy_d;
         cal_busy_q <= cal_busy_d;
      end
   end

   // end-of-activity edges; history resets low, the idle level, so no false edge
   assign conv_done = conv_busy_q & ~conv_busy;
   assign cal_done = cal_busy_q & ~cal_busy;

   // control register: a write loads every field, but only sets conv and start; self-clearing bits
   // drop at the end of their activity, but a fresh write wins that cycle
   always_comb begin
      pm_d = pm_q;
      rsel_d = rsel_q;
      mode_d = mode_q;
      conv_d = conv_q;
      kind_d = kind_q;
      csel_d = csel_q;
      start_d = start_q;
      if (conv_done) begin
         conv_d = 1'b0;
      end
      if (cal_done) begin
         start_d = 1'b0;
      end
      if (rd_req) begin
         mode_d = 1'b0;
      end
      if (ctrl_wr_valid) begin
         pm_d = ctrl_wr_data[CTRL_PM_HI:CTRL_PM_LO];
         rsel_d = ctrl_wr_data[CTRL_RS_HI:CTRL_RS_LO];
         mode_d = ctrl_wr_data[CTRL_MODE];
         kind_d = ctrl_wr_data[CTRL_KIND];
         csel_d = ctrl_wr_data[CTRL_CS_HI:CTRL_CS_LO];
         if (ctrl_wr_data[CTRL_CONV]) begin
            conv_d = 1'b1;
         end
         // with start clear the selection only addresses calibration words
         if (ctrl_wr_data[CTRL_START]) begin
            start_d = 1'b1;
         end
      end
   end

   // control flops; pulses and busy history live in their own groups
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pm_q <= 2'h0;
         rsel_q <= RSEL_RESULT;
         mode_q <= 1'b0;
         conv_q <= 1'b0;
         kind_q <= 1'b0;
         csel_q <= CSEL_ALL;
         start_q <= 1'b0;
      end else begin
         pm_q <= pm_d;
         rsel_q <= rsel_d;
         mode_q <= mode_d;
         conv_q <= conv_d;
         kind_q <= kind_d;
         csel_q <= csel_d;
         start_q <= start_d;
      end
   end

   // start pulses follow every write that sets the bit, so the engine
   // sees a fresh edge even while the level flag is still high
   always_comb begin
      conv_pls_d = ctrl_wr_valid & ctrl_wr_data[CTRL_CONV];
      cal_pls_d = ctrl_wr_valid & ctrl_wr_data[CTRL_START];
   end

   // pulse flops: high for exactly one cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         conv_pls_q <= 1'b0;
         cal_pls_q <= 1'b0;
      end else begin
         conv_pls_q <= conv_pls_d;
         cal_pls_q <= cal_pls_d;
      end
   end

   // live status word; the don't-care bit is driven low
   always_comb begin
      status_now = '0;
      status_now[STAT_BUSY] = conv_busy | cal_busy | conv_q | start_q;
      status_now[STAT_PM_HI:STAT_PM_LO] = pm_q;
      status_now[STAT_ONE_HI] = 1'b1;
      status_now[STAT_ONE_LO] = 1'b1;
      status_now[STAT_MODE] = mode_q;
      status_now[STAT_KIND] = kind_q;
      status_now[STAT_CS_HI:STAT_CS_LO] = csel_q;
      status_now[STAT_CAL] = cal_busy | start_q;
   end

   // a calibration read is a read cycle with read-select on the cal words
   assign cal_rd = rd_req & (rsel_q == RSEL_CAL);
   assign cal_adv = cal_rd | cal_wr_valid;

   // read answer: one cycle after the request, using the select held at
   // the request edge, so a control write in that cycle cannot bend it
   always_comb begin
      rd_valid_d = rd_req;
      rd_data_d = rd_data_q;
      if (rd_req) begin
         unique case (rsel_q)
            RSEL_RESULT: rd_data_d = {CAL_PAD, conv_result};
            RSEL_SPARE: rd_data_d = '0;
            RSEL_CAL: rd_data_d = {CAL_PAD, ptr_word};
            RSEL_STATUS: rd_data_d = status_now;
         endcase
      end
   end

   // answer flops; the data word holds until the next answer
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rd_valid_q <= 1'b0;
         rd_data_q <= STAT_RESET;
      end else begin
         rd_valid_q <= rd_valid_d;
         rd_data_q <= rd_data_d;
      end
   end

   // status copy only moves on status reads, so it stays zero from reset
   // until the first one
   always_comb begin
      stat_d = stat_q;
      if (rd_req && (rsel_q == RSEL_STATUS)) begin
         stat_d = status_now;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stat_q <= STAT_RESET;
      end else begin
         stat_q <= stat_d;
      end
   end

   // register file write port: the calibration engine has priority over
   // the host, since the host is not meant to write during a run
   always_comb begin
      rf_wr = 1'b0;
      rf_idx = ptr;
      rf_data = cal_wr_data;
      if (cal_upd_valid) begin
         rf_wr = 1'b1;
         rf_idx = cal_upd_index;
         rf_data = cal_upd_data;
      end else if (cal_wr_valid) begin
         rf_wr = 1'b1;
      end
   end

   // the walk starts on the selection being written, not the old one
   assign ptr_sel = ctrl_wr_valid ? ctrl_wr_data[CTRL_CS_HI:CTRL_CS_LO] : csel_q;

   // every control write restarts the walk, also ending an aborted one
   adcsc_cal_ptr u_ptr (
      .ref_clk(ref_clk),
      .rst(rst),
      .restart(ctrl_wr_valid),
      .advance(cal_adv),
      .sel(ptr_sel),
      .ptr(ptr)
   );

   adcsc_cal_regs #(
      .N(CAL_N),
      .W(CAL_W)
   ) u_regs (
      .ref_clk(ref_clk),
      .rst(rst),
      .wr_en(rf_wr),
      .wr_idx(rf_idx),
      .wr_data(rf_data),
      .rd_idx_a(ptr),
      .rd_data_a(ptr_word),
      .rd_idx_b(coef_index),
      .rd_data_b(coef_data)
   );

   // outputs, all from flip-flops except the pointer, which is one too
   assign rd_valid = rd_valid_q;
   assign rd_data = rd_data_q;
   assign power_mgmt = pm_q;
   assign interface_mode1 = mode_q;
   assign calibration_kind = kind_q;
   assign cal_select = csel_q;
   assign conversion_trigger = conv_q;
   assign calibration_start_flag = start_q;
   assign conv_start_pulse = conv_pls_q;
   assign cal_start_pulse = cal_pls_q;
   assign cal_pointer = ptr;
   assign status_word = stat_q;
endmodule : adcsc_regs

// >>> bench/adcsc_regs_monitor.sv
`timescale 1ns/1ps
// watches the register block from its ports only
module adcsc_regs_monitor
   import adcsc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ctrl_wr_valid,
   input wire logic [CTRL_W-1:0] ctrl_wr_data,
   input wire logic cal_wr_valid,
   input wire logic rd_req,
   input wire logic rd_valid,
   input wire logic interface_mode1,
   input wire logic [1:0] cal_select,
   input wire logic [CAL_IDX_W-1:0] cal_pointer,
   input wire logic [STAT_W-1:0] status_word
);
   default clocking mon_cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // answer timing of a read cycle
   a_rd_answer: assert property (rd_req |=> rd_valid)
      else $error("read not answered after one cycle");
   a_rd_pulse: assert property (!rd_req |=> !rd_valid)
      else $error("read answer without request");
   // fixed bits of the status copy
   a_stat_zeros: assert property ((status_word & 16'hbc00) == 16'h0000)
      else $error("status zero bits set");
   a_stat_ones: assert property (status_word != STAT_RESET |-> status_word[7:6] == 2'h3)
      else $error("status id bits not one");
   // a write in the same cycle wins, so only a bare read clears the mode
   a_mode_clear: assert property (rd_req && !ctrl_wr_valid |=> !interface_mode1)
      else $error("mode bit kept after read");
   // pointer restart and stepping
   a_ptr_gain: assert property (ctrl_wr_valid && ctrl_wr_data[2:1] != CSEL_OFS
      |=> cal_pointer == CAL_IDX_GAIN)
      else $error("pointer not at gain after control write");
   a_ptr_ofs: assert property (ctrl_wr_valid && ctrl_wr_data[2:1] == CSEL_OFS
      |=> cal_pointer == CAL_IDX_OFS)
      else $error("pointer not at offset after control write");
   a_ptr_step: assert property (cal_wr_valid && !ctrl_wr_valid && cal_select == CSEL_ALL
      && cal_pointer != CAL_IDX_LAST |=> cal_pointer == $past(cal_pointer) + 4'h1)
      else $error("pointer did not step");
   a_ptr_wrap: assert property (cal_wr_valid && !ctrl_wr_valid && cal_select == CSEL_ALL
      && cal_pointer == CAL_IDX_LAST |=> cal_pointer == CAL_IDX_GAIN)
      else $error("pointer did not wrap");
endmodule : adcsc_regs_monitor

// >>> bench/adcsc_host.sv
`timescale 1ns/1ps
// host side of the port, one request at a time
module adcsc_host
   import adcsc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [STAT_W-1:0] rd_data,
   output logic ctrl_wr_valid,
   output logic [CTRL_W-1:0] ctrl_wr_data,
   output logic cal_wr_valid,
   output logic [CAL_W-1:0] cal_wr_data,
   output logic rd_req
);
   // idle lines carry junk so a stale word is never mistaken for data
   initial begin
      ctrl_wr_valid = 1'b0;
      ctrl_wr_data = '1;
      cal_wr_valid = 1'b0;
      cal_wr_data = '1;
      rd_req = 1'b0;
   end
   // select fields are written before any status or calibration read
   task automatic wr_ctrl(input logic [CTRL_W-1:0] d);
      @(posedge ref_clk);
      ctrl_wr_valid <= 1'b1;
      ctrl_wr_data <= d;
      @(posedge ref_clk);
      ctrl_wr_valid <= 1'b0;
      ctrl_wr_data <= ~d;
   endtask : wr_ctrl
   // writes and reads are never mixed within one set
   task automatic wr_cal(input logic [CAL_W-1:0] d);
      @(posedge ref_clk);
      cal_wr_valid <= 1'b1;
      cal_wr_data <= d;
      @(posedge ref_clk);
      cal_wr_valid <= 1'b0;
      cal_wr_data <= ~d;
   endtask : wr_cal
   // answer lands one cycle after the request edge
   task automatic rd(output logic [STAT_W-1:0] d);
      @(posedge ref_clk);
      rd_req <= 1'b1;
      @(posedge ref_clk);
      rd_req <= 1'b0;
      #1;
      d = rd_data;
   endtask : rd
endmodule : adcsc_host

// >>> bench/adcsc_regs_tb.sv
`timescale 1ns/1ps
module adcsc_regs_tb;
   import adcsc_pkg::*;
   logic ref_clk, rst, ctrl_wr_valid, cal_wr_valid, rd_req, rd_valid;
   logic conv_busy, cal_busy, cal_upd_valid;
   logic [CTRL_W-1:0] ctrl_wr_data;
   logic [CAL_W-1:0] cal_wr_data, conv_result, cal_upd_data, coef_data;
   logic [CAL_IDX_W-1:0] cal_upd_index, coef_index;
   logic [STAT_W-1:0] rd_data, status_word, v;
   logic [CAL_W-1:0] vals [10];
   logic [1:0] power_mgmt;
   logic calibration_kind, conversion_trigger, calibration_start_flag;
   logic conv_start_pulse, cal_start_pulse;
   int mismatches = 0;
   int cmp_count = 0;

   adcsc_regs i_adcsc_regs (.ref_clk, .rst, .ctrl_wr_valid, .ctrl_wr_data, .cal_wr_valid,
      .cal_wr_data, .rd_req, .rd_valid, .rd_data, .conv_result, .conv_busy, .cal_busy,
      .cal_upd_valid, .cal_upd_index, .cal_upd_data, .coef_index, .coef_data,
      .power_mgmt, .interface_mode1(), .calibration_kind, .cal_select(),
      .conversion_trigger, .calibration_start_flag, .conv_start_pulse,
      .cal_start_pulse, .cal_pointer(), .status_word);
   adcsc_host i_adcsc_host (.ref_clk, .rd_data, .ctrl_wr_valid, .ctrl_wr_data,
      .cal_wr_valid, .cal_wr_data, .rd_req);

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // one read cycle, answer flag and word both compared
   task automatic rdx(input logic [15:0] exp);
      i_adcsc_host.rd(v);
      chk({15'h0, rd_valid}, 16'h0001);
      chk(v, exp);
   endtask : rdx

   task automatic stop_test();
      if (mismatches == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test

   // about 140 cycles of traffic; the limit leaves wide margin
   initial begin
      #500000;
      mismatches++;
      stop_test();
   end

   initial begin
      rst = 1'b1;
      conv_busy = 1'b0;
      cal_busy = 1'b0;
      cal_upd_valid = 1'b0;
      cal_upd_index = 4'h5;
      cal_upd_data = 14'h1abc;
      conv_result = 14'h3fff;
      coef_index = 4'h5;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      chk(status_word, STAT_RESET);
      rdx(16'h3fff);
      // status read with every field but conv and start set to something distinct
      i_adcsc_host.wr_ctrl(14'h02ea);
      rdx(16'h02ea);
      chk({13'h0, power_mgmt, calibration_kind}, 16'h0005);
      i_adcsc_host.wr_ctrl(14'h00c0);
      chk(status_word, 16'h02ea);
      rdx(16'h00c0);
      i_adcsc_host.wr_ctrl(14'h02ea);
      rdx(16'h02ea);
      rdx(16'h02ca);
      @(posedge ref_clk) conv_busy <= 1'b1;
      rdx(16'h42ca);
      conv_busy <= 1'b0;
      cal_busy <= 1'b1;
      rdx(16'h42cb);
      cal_busy <= 1'b0;
      // software conversion start; the end of the conversion drops the trigger
      i_adcsc_host.wr_ctrl(14'h00d0);
      #1;
      chk({14'h0, conv_start_pulse, conversion_trigger}, 16'h0003);
      rdx(16'h40c0);
      chk({14'h0, conv_start_pulse, conversion_trigger}, 16'h0001);
      @(posedge ref_clk) conv_busy <= 1'b1;
      @(posedge ref_clk) conv_busy <= 1'b0;
      rdx(16'h00c0);
      chk({15'h0, conversion_trigger}, 16'h0000);
      // system calibration start; its end drops the start flag
      i_adcsc_host.wr_ctrl(14'h00c9);
      #1;
      chk({14'h0, cal_start_pulse, calibration_start_flag}, 16'h0003);
      rdx(16'h40c9);
      @(posedge ref_clk) cal_busy <= 1'b1;
      @(posedge ref_clk) cal_busy <= 1'b0;
      rdx(16'h00c8);
      chk({14'h0, cal_start_pulse, calibration_start_flag}, 16'h0000);
      // the spare read select answers zero
      i_adcsc_host.wr_ctrl(14'h0040);
      rdx(16'h0000);
      // fill the full set, then read it back past the wrap
      i_adcsc_host.wr_ctrl(14'h0000);
      conv_result <= 14'h0a5c;
      rdx(16'h0a5c);
      for (int i = 0; i < 10; i++) begin
         vals[i] = 14'h3ff0 - 14'(i);
         i_adcsc_host.wr_cal(vals[i]);
      end
      i_adcsc_host.wr_ctrl(14'h0080);
      for (int i = 0; i < 11; i++) rdx({2'h0, vals[i % 10]});
      // the three smaller sets, each read three times, past its length
      for (int s = 1; s < 4; s++) begin
         i_adcsc_host.wr_ctrl(14'h0080 | 14'(s << 1));
         for (int k = 0; k < 3; k++) rdx({2'h0, vals[s == 1 ? k % 2 : int'(s == 2)]});
      end
      // abandon a sequence midway
      i_adcsc_host.wr_ctrl(14'h0080);
      for (int k = 0; k < 3; k++) rdx({2'h0, vals[k]});
      i_adcsc_host.wr_ctrl(14'h0080);
      rdx({2'h0, vals[0]});
      // engine update lands without any host write
      @(posedge ref_clk) cal_upd_valid <= 1'b1;
      @(posedge ref_clk) cal_upd_valid <= 1'b0;
      #1;
      chk({2'h0, coef_data}, 16'h1abc);
      // a second engine update, on the offset word, seen by the host too
      cal_upd_index <= 4'h1;
      cal_upd_data <= 14'h2b3c;
      coef_index <= 4'h1;
      @(posedge ref_clk) cal_upd_valid <= 1'b1;
      @(posedge ref_clk) cal_upd_valid <= 1'b0;
      #1;
      chk({2'h0, coef_data}, 16'h2b3c);
      i_adcsc_host.wr_ctrl(14'h0084);
      rdx(16'h2b3c);
      stop_test();
   end
endmodule : adcsc_regs_tb

bind adcsc_regs adcsc_regs_monitor i_adcsc_regs_monitor (.ref_clk, .rst, .ctrl_wr_valid,
   .ctrl_wr_data, .cal_wr_valid, .rd_req, .rd_valid, .interface_mode1, .cal_select,
   .cal_pointer, .status_word);
